// >>> fsb_ctrl.sv
// Top of the flow-through burst SRAM control: cycle decode, burst
// sequencing, lane write strobes, data pin drive and sleep handling.
// Assumes a memory controller on the far side; pins except output enable pass two flops.
//
// Functional notes
// - Burst select low steps low address bits linearly, adding one modulo four.
// - Burst select high gives interleaved order, start XOR step count.
// - All selects active, load, write enable high, awake starts read at address.
// - Step input high continues read burst at next address, ignoring selects.
// - Read with output enable inactive is dummy; address advances, pins stay off.
// - Selects active, load, write enable low, some lane low starts write burst.
// - Step during write burst with a lane low writes selected lanes next address.
// - Write start with no lanes selected is a no-op, nothing written.
// - Continuing write with no lanes advances address, leaves memory unchanged.
// - Clock-qualify high makes the edge ignored; access and address state is held, pin flops and sleep tracking still run.
// - Any write cycle tri-states all data and parity pins.
// - Output enable is asynchronous, unsampled, masked during write cycles.
// - Read drives pins only while output enable active and selected.
// - After power-up the device is deselected with pins tri-stated.
// - Each lane select gates its byte and parity; any combination allowed.
// - Write enable high reads regardless of lanes; low with no lanes writes none.
// - Sleep is entered within two cycles; inputs ignored, pins off, data kept.
// - Inactive select at load deselects at once; step then continues deselect.
// - Burst direction captured at burst start, held for the whole burst.
// - Write data follows address by one clock and is captured then.
`timescale 1ns/1ps
module fsb_ctrl #(
   parameter int unsigned ADDR_W = fsb_pkg::ADDR_W,
   parameter int unsigned LANES = fsb_pkg::LANES,
   parameter int unsigned LANE_W = fsb_pkg::LANE_W
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic clock_qualify_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire fsb_pkg::fsb_ctrl_t ctrl_i,
   input wire logic burst_mode_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic [LANES*LANE_W-1:0] data_i,
   output logic [LANES*LANE_W-1:0] data_o,
   output logic data_oe_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [LANES-1:0] mem_lane_we_o,
   output logic [LANES*LANE_W-1:0] mem_wdata_o,
   input wire logic [LANES*LANE_W-1:0] mem_rdata_i,
   output logic asleep_o
);
   localparam int unsigned DW = LANES * LANE_W;

   // Pin synchronisers
   fsb_pkg::fsb_ctrl_t ctrl_s1_reg;
   fsb_pkg::fsb_ctrl_t ctrl_s2_reg;
   logic [ADDR_W-1:0] addr_s1_reg;
   logic [ADDR_W-1:0] addr_s2_reg;
   logic [DW-1:0] data_s1_reg;
   logic [DW-1:0] data_s2_reg;
   logic [1:0] qual_s_reg;
   logic [1:0] mode_s_reg;

   fsb_pkg::fsb_op_t op_reg;
   logic [ADDR_W-1:2] base_reg;
   logic wr_pend_reg;
   logic [LANES-1:0] wr_lanes_reg;
   logic [DW-1:0] rdata_reg;
   logic [1:0] burst_addr;
   logic asleep;
   logic recovering;
   logic qual_edge;
   logic sel_all;
   logic load;
   logic step;
   logic start_rd;
   logic start_wr;
   logic any_lane;

   // Every pin except output enable passes two flops before decode
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_s1_reg <= '0;
         ctrl_s2_reg <= '0;
         addr_s1_reg <= '0;
         addr_s2_reg <= '0;
         data_s1_reg <= '0;
         data_s2_reg <= '0;
         qual_s_reg <= 2'h3;
         mode_s_reg <= 2'h3;
      end
      else
      begin
         ctrl_s1_reg <= ctrl_i;
         ctrl_s2_reg <= ctrl_s1_reg;
         addr_s1_reg <= addr_i;
         addr_s2_reg <= addr_s1_reg;
         data_s1_reg <= data_i;
         data_s2_reg <= data_s1_reg;
         qual_s_reg <= {qual_s_reg[0], clock_qualify_n_i};
         mode_s_reg <= {mode_s_reg[0], burst_mode_i};
      end
   end

   // Sleep takes precedence over any decoded cycle
   fsb_sleep_ctl u_sleep (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .sleep_request_i(sleep_request_i),
      .asleep_o(asleep),
      .recovering_o(recovering)
   );

   // Cycle decode; stalled and sleeping edges do nothing
   // Exit from sleep also takes two cycles, so edges in recovery are ignored
   assign qual_edge = !qual_s_reg[1] && !asleep && !recovering;
   assign sel_all = !ctrl_s2_reg.chip_sel_first_n && ctrl_s2_reg.chip_sel_second
                    && !ctrl_s2_reg.chip_sel_third_n;
   assign load = qual_edge && !ctrl_s2_reg.burst_step_or_load;
   assign step = qual_edge && ctrl_s2_reg.burst_step_or_load;
   assign any_lane = !(&ctrl_s2_reg.lane_write_n);
   assign start_rd = load && sel_all && ctrl_s2_reg.write_en_n;
   assign start_wr = load && sel_all && !ctrl_s2_reg.write_en_n;

   // Operation type latched at load, held through the burst
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         op_reg <= fsb_pkg::FSB_IDLE;
      else if (asleep)
         op_reg <= fsb_pkg::FSB_IDLE; // Pending access is abandoned
      else if (load)
      begin
         if (start_rd)
            op_reg <= fsb_pkg::FSB_READ;
         else if (start_wr)
            op_reg <= fsb_pkg::FSB_WRITE;
         else
            op_reg <= fsb_pkg::FSB_IDLE;
      end
   end

   // Upper address captured at burst start
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         base_reg <= '0;
      else if (start_rd || start_wr)
         base_reg <= addr_s2_reg[ADDR_W-1:2];
   end

   // Low address bits; a no-lane write start uses no address
   fsb_burst_seq u_seq (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .load_i(start_rd || (start_wr && any_lane)),
      .step_i(step && op_reg != fsb_pkg::FSB_IDLE),
      .interleave_i(mode_s_reg[1]),
      .start_i(addr_s2_reg[1:0]),
      .addr_o(burst_addr)
   );

   assign mem_addr_o = {base_reg, burst_addr};

   // Write beat pending: data arrives on the next qualified edge
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_pend_reg <= 1'b0;
         wr_lanes_reg <= '0;
      end
      else if (asleep)
         wr_pend_reg <= 1'b0;
      else if (qual_edge)
      begin
         wr_pend_reg <= (start_wr || (step && op_reg == fsb_pkg::FSB_WRITE))
                        && any_lane;
         wr_lanes_reg <= ~ctrl_s2_reg.lane_write_n;
      end
   end

   // Memory write strobes per lane, data one edge after address
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         assign mem_lane_we_o[g] = wr_pend_reg && qual_edge && wr_lanes_reg[g];
      end
   endgenerate
   assign mem_wdata_o = data_s2_reg;

   // Read data registered from the array
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_reg <= '0;
      else if (op_reg == fsb_pkg::FSB_READ)
         rdata_reg <= mem_rdata_i;
   end
   assign data_o = rdata_reg;

   // Output enable is used raw, masked by writes, deselect and sleep
   assign data_oe_o = (op_reg == fsb_pkg::FSB_READ) && !output_enable_n_i
                      && !asleep && !wr_pend_reg;
   assign asleep_o = asleep;

   // Checks
   sequence write_start_s;
      start_wr && any_lane;
   endsequence
   sequence write_beat_s;
      step && op_reg == fsb_pkg::FSB_WRITE && any_lane;
   endsequence
   write_oe_mask_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (op_reg == fsb_pkg::FSB_WRITE) |-> !data_oe_o)
      else $error("pins driven during write");
   write_strobe_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      write_start_s ##1 qual_edge |-> (mem_lane_we_o != '0))
      else $error("write not committed");
   noop_write_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (start_wr && !any_lane) ##1 qual_edge |-> (mem_lane_we_o == '0))
      else $error("no-lane write wrote");
   stall_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (qual_s_reg[1] && !asleep) |=> $stable(op_reg) && $stable(mem_addr_o))
      else $error("state changed on stalled edge");
   read_start_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      start_rd |=> (op_reg == fsb_pkg::FSB_READ)
         && mem_addr_o == $past(addr_s2_reg))
      else $error("read not started at address");
   deselect_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (load && !sel_all) |=> !data_oe_o && op_reg == fsb_pkg::FSB_IDLE)
      else $error("deselect failed");
   burst_dir_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (step && !asleep) |=> $stable(op_reg))
      else $error("direction changed in burst");
   sleep_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      asleep |-> !data_oe_o && mem_lane_we_o == '0)
      else $error("activity during sleep");
   oe_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (op_reg == fsb_pkg::FSB_READ && !wr_pend_reg && !asleep)
         |-> data_oe_o == !output_enable_n_i)
      else $error("read drive mismatch");

   // Continuing beat moves the low bits only, upper address is kept
   seq_advance_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (step && op_reg != fsb_pkg::FSB_IDLE)
         |=> mem_addr_o[1:0] != $past(mem_addr_o[1:0])
            && mem_addr_o[ADDR_W-1:2] == $past(mem_addr_o[ADDR_W-1:2]))
      else $error("burst address did not advance");

   // Read with the enable pin inactive must leave the pins undriven
   dummy_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (op_reg == fsb_pkg::FSB_READ && output_enable_n_i) |-> !data_oe_o)
      else $error("dummy read drove pins");

   // Beat with no lanes advances but writes nothing
   abort_beat_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (step && op_reg == fsb_pkg::FSB_WRITE && !any_lane) |=> mem_lane_we_o == '0)
      else $error("aborted beat wrote");

   // Continuing beat strobes exactly the lanes selected for it
   beat_strobe_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      write_beat_s ##1 qual_edge
         |-> mem_lane_we_o == $past(~ctrl_s2_reg.lane_write_n))
      else $error("burst beat lanes wrong");

   // Sleep drops any pending access
   sleep_idle_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      asleep |=> op_reg == fsb_pkg::FSB_IDLE && !wr_pend_reg)
      else $error("access kept across sleep");

   // No access starts while leaving sleep
   wake_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      recovering |-> !start_rd && !start_wr)
      else $error("access during sleep exit");

   // A read start never writes, whatever the lane selects say
   read_lanes_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      start_rd |=> op_reg == fsb_pkg::FSB_READ && mem_lane_we_o == '0)
      else $error("read start wrote");

   // Outside a read the pins are never driven
   idle_oe_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (op_reg != fsb_pkg::FSB_READ) |-> !data_oe_o)
      else $error("pins driven outside read");

   // Pending write data masks the raw enable pin
   pend_mask_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      wr_pend_reg |-> !data_oe_o)
      else $error("enable not masked in write");
endmodule : fsb_ctrl

// >>> fsb_pkg.sv
// Shared types and constants for the flow-through burst SRAM control block.
// Assumes a single clock domain; no registers reachable by software.
package fsb_pkg;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned LANES = 2;
   localparam int unsigned LANE_W = 9;
   localparam int unsigned DATA_W = LANES * LANE_W;
   // Sleep entry and recovery, in clock periods
   localparam int unsigned SLEEP_ENTRY_CYC = 2;
   localparam int unsigned SLEEP_RECOVERY_CYC = 2;
   localparam logic [1:0] BURST_STEP_ONE = 2'h1;

   typedef enum logic [1:0] {FSB_IDLE, FSB_READ, FSB_WRITE} fsb_op_t;

   // Synchronous controls sampled on a qualified edge
   typedef struct packed {
      logic chip_sel_first_n;
      logic chip_sel_second;
      logic chip_sel_third_n;
      logic burst_step_or_load;
      logic write_en_n;
      logic [LANES-1:0] lane_write_n;
   } fsb_ctrl_t;
endpackage : fsb_pkg

// >>> fsb_burst_seq.sv
// Two-bit burst address sequencer, linear or interleaved.
// Assumes the caller loads and steps it on qualified edges only.
`timescale 1ns/1ps
module fsb_burst_seq (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic load_i,
   input wire logic step_i,
   input wire logic interleave_i,
   input wire logic [1:0] start_i,
   output logic [1:0] addr_o
);
   logic [1:0] start_reg;
   logic [1:0] count_reg;

   // Start value and step count; address derived from both
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         start_reg <= 2'h0;
         count_reg <= 2'h0;
      end
      else if (load_i)
      begin
         start_reg <= start_i;
         count_reg <= 2'h0;
      end
      else if (step_i)
         count_reg <= count_reg + fsb_pkg::BURST_STEP_ONE; // Wraps modulo four
   end

   // Linear adds, interleaved xors the step count
   assign addr_o = interleave_i ? (start_reg ^ count_reg)
                                : (start_reg + count_reg);

   property seq_linear_p;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (!interleave_i) |-> addr_o == 2'(start_reg + count_reg);
   endproperty
   linear_order_a: assert property (seq_linear_p)
      else $error("linear burst address wrong");
   interleave_order_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (step_i && !load_i && interleave_i && $stable(interleave_i))
         |=> (addr_o ^ $past(addr_o)) == (count_reg ^ $past(count_reg)))
      else $error("interleaved burst address wrong");
endmodule : fsb_burst_seq

// >>> fsb_sleep_ctl.sv
// Sleep-request synchroniser and sleep state tracker.
// Assumes the request pin is asynchronous to the reference clock.
`timescale 1ns/1ps
module fsb_sleep_ctl (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic sleep_request_i,
   output logic asleep_o,
   output logic recovering_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic [1:0] rec_cnt_reg;

   // Two-flop synchroniser; its two stages give the two-cycle entry
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= sleep_request_i;
         sync2_reg <= sync1_reg;
      end
   end

   assign asleep_o = sync2_reg;

   // Recovery window after wake; accesses are not expected here
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rec_cnt_reg <= 2'h0;
      else if (sync2_reg)
         rec_cnt_reg <= 2'(fsb_pkg::SLEEP_RECOVERY_CYC);
      else if (rec_cnt_reg != 2'h0)
         rec_cnt_reg <= rec_cnt_reg - 2'h1;
   end

   assign recovering_o = (rec_cnt_reg != 2'h0);

   sleep_entry_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(sleep_request_i) ##0 sleep_request_i [*3] |-> ##[0:2] asleep_o)
      else $error("sleep not entered within two cycles");
endmodule : fsb_sleep_ctl

// >>> fsb_array_model.sv
// Behavioural storage array standing behind the burst SRAM control block.
// Assumes per-lane strobes act at the rising edge with the address shown.
`timescale 1ns/1ps
module fsb_array_model (
   input wire logic ref_clk_i,
   input wire logic [17:0] mem_addr_i,
   input wire logic [1:0] mem_lane_we_i,
   input wire logic [17:0] mem_wdata_i,
   output logic [17:0] mem_rdata_o
);
   // Small window of the array; upper address bits are folded away
   logic [17:0] mem [0:255];

   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 18'h0;
   end

   // Each strobe writes its byte with its parity bit only
   always_ff @(posedge ref_clk_i)
   begin
      if (mem_lane_we_i[0])
         mem[mem_addr_i[7:0]][8:0] <= mem_wdata_i[8:0];
      if (mem_lane_we_i[1])
         mem[mem_addr_i[7:0]][17:9] <= mem_wdata_i[17:9];
   end

   // Flow-through read, same clock
   assign mem_rdata_o = mem[mem_addr_i[7:0]];
endmodule : fsb_array_model

// >>> flowthrough_sram_burst_control_bench.sv
// Self-checking bench for the burst SRAM control block.
// Assumes the array model file is compiled first; bench plays the controller.
`timescale 1ns/1ps
module flowthrough_sram_burst_control_bench;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic clock_qualify_n_i = 1'b0;
   logic [17:0] addr_i = 18'h0;
   fsb_pkg::fsb_ctrl_t ctrl_i;
   logic burst_mode_i = 1'b0;
   logic output_enable_n_i = 1'b0;
   logic sleep_request_i = 1'b0;
   logic [17:0] data_i = 18'h0;
   logic [17:0] data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic data_oe_o, asleep_o;
   logic [1:0] mem_lane_we_o;
   int errors = 0;
   int checked = 0;

   fsb_ctrl dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .clock_qualify_n_i(clock_qualify_n_i), .addr_i(addr_i), .ctrl_i(ctrl_i),
      .burst_mode_i(burst_mode_i), .output_enable_n_i(output_enable_n_i),
      .sleep_request_i(sleep_request_i), .data_i(data_i), .data_o(data_o),
      .data_oe_o(data_oe_o), .mem_addr_o(mem_addr_o), .mem_lane_we_o(mem_lane_we_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .asleep_o(asleep_o));

   fsb_array_model arr_u (.ref_clk_i(ref_clk_i), .mem_addr_i(mem_addr_o),
      .mem_lane_we_i(mem_lane_we_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   // 125 MHz clock
   initial
   begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Set the synchronous pins; sel high means all three selects active
   task automatic pins(input logic sel, input logic step, input logic we_n,
                       input logic [1:0] ln, input logic [17:0] a);
      ctrl_i = '{~sel, sel, ~sel, step, we_n, ln};
      addr_i = a;
   endtask : pins

   // Four-beat burst; write data trails its address by one clock
   task automatic burst(input logic [17:0] a, input logic we_n,
                        input logic [3:0][1:0] ln, input logic [3:0][17:0] d);
      for (int i = 0; i < 5; i++)
      begin
         if (i == 0)
            pins(1'b1, 1'b0, we_n, ln[0], a);
         else if (i < 4)
            pins(1'b0, 1'b1, ~we_n, ln[i], ~a); // selects and enable ignored
         else
            pins(1'b0, 1'b0, 1'b1, 2'h3, a);
         data_i = (i > 0) ? d[i-1] : ~d[0];
         cyc(1);
         if (!we_n)
            chk("oe in write", 18'h0, {17'h0, data_oe_o});
      end
      data_i = ~data_i;
      cyc(8);
   endtask : burst

   task automatic t_linear;
      burst(18'h11, 1'b0, '0, {18'h3c004, 18'h3c003, 18'h3c002, 18'h3c001});
      chk("lin 11", 18'h3c001, arr_u.mem[8'h11]);
      chk("lin 12", 18'h3c002, arr_u.mem[8'h12]);
      chk("lin 13", 18'h3c003, arr_u.mem[8'h13]);
      chk("lin 10", 18'h3c004, arr_u.mem[8'h10]);
   endtask : t_linear

   task automatic t_interleave;
      burst_mode_i = 1'b1;
      cyc(4);
      burst(18'h21, 1'b0, {2'h1, 2'h2, 2'h3, 2'h0}, {4{18'h3ffff}});
      chk("ilv 21", 18'h3ffff, arr_u.mem[8'h21]);
      chk("ilv 20", 18'h0, arr_u.mem[8'h20]);
      chk("ilv 23", 18'h001ff, arr_u.mem[8'h23]);
      chk("ilv 22", 18'h3fe00, arr_u.mem[8'h22]);
      burst_mode_i = 1'b0;
      cyc(4);
   endtask : t_interleave

   task automatic t_abort;
      burst(18'h11, 1'b0, {4{2'h3}}, {4{18'h0}});
      chk("abort 11", 18'h3c001, arr_u.mem[8'h11]);
      chk("abort 12", 18'h3c002, arr_u.mem[8'h12]);
   endtask : t_abort

   task automatic t_read;
      pins(1'b1, 1'b0, 1'b1, 2'h0, 18'h13); // lanes low still read
      output_enable_n_i = 1'b0;
      cyc(8);
      chk("read oe", 18'h1, {17'h0, data_oe_o});
      chk("read data", 18'h3c003, data_o);
      output_enable_n_i = 1'b1;
      #1;
      chk("oe async off", 18'h0, {17'h0, data_oe_o});
      cyc(2);
      chk("dummy read", 18'h0, {17'h0, data_oe_o});
      output_enable_n_i = 1'b0;
      pins(1'b0, 1'b0, 1'b1, 2'h3, 18'h0);
      cyc(6);
      chk("deselect oe", 18'h0, {17'h0, data_oe_o});
   endtask : t_read

   task automatic t_stall;
      clock_qualify_n_i = 1'b1;
      burst(18'h30, 1'b0, '0, {4{18'h2aaaa}});
      clock_qualify_n_i = 1'b0;
      cyc(6);
      chk("stall 30", 18'h0, arr_u.mem[8'h30]);
   endtask : t_stall

   // Controller drives a write burst while asleep and waits out recovery
   task automatic t_sleep;
      sleep_request_i = 1'b1;
      cyc(5);
      chk("asleep", 18'h1, {17'h0, asleep_o});
      burst(18'h40, 1'b0, '0, {4{18'h15555}});
      chk("sleep oe", 18'h0, {17'h0, data_oe_o});
      sleep_request_i = 1'b0;
      cyc(10);
      chk("awake", 18'h0, {17'h0, asleep_o});
      chk("sleep 40", 18'h0, arr_u.mem[8'h40]);
      chk("kept 12", 18'h3c002, arr_u.mem[8'h12]);
   endtask : t_sleep

   task automatic report_and_stop;
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Run takes about 120 cycles; allow ample margin
   initial
   begin
      #40000;
      errors++;
      report_and_stop();
   end

   initial
   begin
      pins(1'b0, 1'b0, 1'b1, 2'h3, 18'h0);
      cyc(8);
      chk("reset oe", 18'h0, {17'h0, data_oe_o});
      nrst_i = 1'b1;
      cyc(4);
      chk("powerup oe", 18'h0, {17'h0, data_oe_o});
      t_linear();
      t_interleave();
      t_abort();
      t_read();
      t_stall();
      t_sleep();
      report_and_stop();
   end
endmodule : flowthrough_sram_burst_control_bench
